//--- rtl/chhs_pkg.sv
// package with shared constants and the mode enum for the card host handshake link
package chhs_pkg;
  // operating modes selected by the host
  typedef enum logic [1:0] {CHHS_MEM, CHHS_IO, CHHS_IDE} chhs_mode_t;
  localparam int          CHHS_DATA_W     = 16;
  localparam logic [3:0]  CHHS_INIT_CYC   = 4'hA;  // card stays busy this many link cycles after reset, plus one
  localparam logic [3:0]  CHHS_INIT_RST   = 4'h0;  // init counter value after reset
  localparam logic [2:0]  CHHS_WAIT_CYC   = 3'h3;  // link cycles card stretches a strobe cycle
  localparam logic [2:0]  CHHS_CLK_DIV    = 3'h2;  // host divides clk_in by 2*(this) for the link clock
  localparam logic [3:0]  CHHS_HOLD_CYC   = 4'hC;  // host clk_in cycles a strobe stays low before wait is trusted
  localparam logic [15:0] CHHS_CFG_RST    = 16'h0000;
endpackage

//--- rtl/chhs_if.sv
// interface joining the card end and the host end of the parallel port
`timescale 1ns/1ps
interface chhs_if;
  logic        link_clk;       // link clock, made by the host
  logic        reset_n;        // host reset, low active
  logic        ide_mode_select_n; // low selects ide mode
  logic        io_mode;        // high selects io mode when not ide
  logic        we_n;           // memory/config write strobe
  logic        iowr_n;         // io/task-file write strobe
  logic        udma_wr;        // host requests udma write burst
  logic        udma_rd;        // host requests udma read burst
  logic        host_pause;     // host pauses a read burst
  logic        word_port;      // addressed port is a 16 bit port
  logic [15:0] wdata;          // host write data
  logic        ready;          // card not busy
  logic        wait_n;         // shared wait / iordy / ready pin
  logic        wp_16_n;        // shared write-protect / iois16 / iocs16 pin
  logic        dstrobe;        // card read strobe
  logic [15:0] rdata;          // card read data
  modport card (input link_clk, reset_n, ide_mode_select_n, io_mode, we_n, iowr_n, udma_wr, udma_rd,
                input host_pause, word_port, wdata, output ready, wait_n, wp_16_n, dstrobe, rdata);
  modport host (output link_clk, reset_n, ide_mode_select_n, io_mode, we_n, iowr_n, udma_wr, udma_rd,
                output host_pause, word_port, wdata, input ready, wait_n, wp_16_n, dstrobe, rdata);
endinterface

//--- rtl/chhs_card.sv
// card end: handshake and status outputs in the three operating modes
`timescale 1ns/1ps
module chhs_card
(
  chhs_if.card       link,
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  input  wire logic  core_busy_in,
  output logic       cfg_valid_out,
  output logic [15:0] cfg_data_out,
  output logic [15:0] task_data_out,
  input  wire logic  [15:0] rd_data_in
);
  typedef struct packed {
    logic [3:0]  init_cnt;
    logic        init_done;
    logic [2:0]  wait_cnt;
    logic        we_q;
    logic        iowr_q;
    logic        strobe;
    logic [15:0] cfg;
    logic [15:0] task_reg;
    logic [15:0] rdata;
    logic        cfg_tgl;
  } chhs_card_state_t;
  chhs_card_state_t s_q;
  chhs_card_state_t s_d;
  chhs_pkg::chhs_mode_t mode;
  logic busy_s1_q;
  logic busy_s2_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic we_fall;
  logic iowr_fall;
  // mode decode from the select pins
  always_comb
  begin
    if (!link.ide_mode_select_n)
      mode = chhs_pkg::CHHS_IDE;
    else if (link.io_mode)
      mode = chhs_pkg::CHHS_IO;
    else
      mode = chhs_pkg::CHHS_MEM;
  end
  assign we_fall = s_q.we_q && !link.we_n;
  assign iowr_fall = s_q.iowr_q && !link.iowr_n;
  // link-domain next state
  always_comb
  begin
    s_d = s_q;
    s_d.we_q = link.we_n;
    s_d.iowr_q = link.iowr_n;
    if (!s_q.init_done)
    begin
      s_d.init_cnt = s_q.init_cnt + 4'h1;
      if (s_q.init_cnt == chhs_pkg::CHHS_INIT_CYC)
        s_d.init_done = 1'b1;
    end
    // stretch each strobe cycle, except a we_n strobe in ide mode, for a fixed count that pauses while the core is busy
    if ((we_fall && mode != chhs_pkg::CHHS_IDE) || iowr_fall)
      s_d.wait_cnt = chhs_pkg::CHHS_WAIT_CYC;
    else if (s_q.wait_cnt != 3'h0 && !busy_s2_q)
      s_d.wait_cnt = s_q.wait_cnt - 3'h1;
    // write strobe: memory and io modes write config, ide ignores it; io strobe writes task_reg outside memory mode
    if (we_fall && s_q.init_done && mode != chhs_pkg::CHHS_IDE)
    begin
      s_d.cfg = link.wdata;
      s_d.cfg_tgl = !s_q.cfg_tgl;
    end
    if (iowr_fall && s_q.init_done && mode != chhs_pkg::CHHS_MEM)
      s_d.task_reg = link.wdata;
    // read burst: a new edge each cycle unless paused or the core is busy
    if (link.udma_rd && mode == chhs_pkg::CHHS_IDE && !link.host_pause && !busy_s2_q)
    begin
      s_d.strobe = !s_q.strobe;
      s_d.rdata = rd_data_in;
    end
    if (!link.reset_n)
    begin
      s_d = '0;
      s_d.we_q = 1'b1;
      s_d.iowr_q = 1'b1;
      s_d.init_cnt = chhs_pkg::CHHS_INIT_RST;
      s_d.cfg = chhs_pkg::CHHS_CFG_RST;
    end
  end
  // link-domain registers
  always_ff @(posedge link.link_clk)
    s_q <= s_d;
  // core busy into the link domain
  always_ff @(posedge link.link_clk)
  begin
    busy_s1_q <= core_busy_in;
    busy_s2_q <= busy_s1_q;
  end
  // pin outputs by mode
  always_comb
  begin
    link.ready = s_q.init_done;
    link.dstrobe = s_q.strobe;
    link.rdata = s_q.rdata;
    if (mode == chhs_pkg::CHHS_IDE && link.udma_wr)
      link.wait_n = s_q.init_done && !busy_s2_q;
    else if (mode == chhs_pkg::CHHS_IDE)
      link.wait_n = (s_q.wait_cnt == 3'h0);
    else
      link.wait_n = (s_q.wait_cnt == 3'h0);
    unique case (mode)
      chhs_pkg::CHHS_MEM: link.wp_16_n = 1'b0;
      chhs_pkg::CHHS_IO:  link.wp_16_n = !link.word_port;
      chhs_pkg::CHHS_IDE: link.wp_16_n = !(link.word_port && (link.udma_rd || link.udma_wr));
    endcase
    if (!s_q.init_done && mode == chhs_pkg::CHHS_MEM)
      link.wp_16_n = 1'b1;
  end
  // config toggle crosses to core clock
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      cfg_valid_out <= 1'b0;
      cfg_data_out <= 16'h0000;
      task_data_out <= 16'h0000;
    end
    else
    begin
      tgl_s1_q <= s_q.cfg_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      cfg_valid_out <= tgl_s2_q ^ tgl_s3_q;
      if (tgl_s2_q ^ tgl_s3_q)
        cfg_data_out <= s_q.cfg; // stable for many cycles after the toggle
      task_data_out <= s_q.task_reg;
    end
  end
endmodule

//--- rtl/chhs_host.sv
// host end: drives strobes, mode and link clock; samples card status
`timescale 1ns/1ps
module chhs_host
(
  chhs_if.host        link,
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  input  wire logic   ide_sel_in,
  input  wire logic   io_sel_in,
  input  wire logic   wr_req_in,
  input  wire logic   wr_io_in,
  input  wire logic   [15:0] wr_data_in,
  input  wire logic   rd_burst_in,
  input  wire logic   rd_pause_in,
  output logic        wr_done_out,
  output logic        rd_valid_out,
  output logic [15:0] rd_data_out
);
  typedef enum {CHHS_H_IDLE, CHHS_H_STROBE, CHHS_H_HOLD} chhs_hstate_t;
  typedef struct packed {
    logic [2:0]  div;
    logic        lclk;
    chhs_hstate_t st;
    logic [3:0]  hold;
    logic        we_n;
    logic        iowr_n;
    logic        io;
    logic [15:0] wdata;
    logic        rdy_s1;
    logic        rdy_s2;
    logic        wt_s1;
    logic        wt_s2;
    logic        ds_s1;
    logic        ds_s2;
    logic        ds_s3;
    logic [15:0] rd_s1;
    logic        done;
    logic        rvalid;
    logic [15:0] rdata;
  } chhs_host_state_t;
  chhs_host_state_t s_q;
  chhs_host_state_t s_d;
  // link clock divider, strobe sequencer and input sampling
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.div = s_q.div + 3'h1;
    if (s_q.div == chhs_pkg::CHHS_CLK_DIV - 3'h1)
    begin
      s_d.div = 3'h0;
      s_d.lclk = !s_q.lclk;
    end
    s_d.rdy_s1 = link.ready;
    s_d.rdy_s2 = s_q.rdy_s1;
    s_d.wt_s1 = link.wait_n;
    s_d.wt_s2 = s_q.wt_s1;
    s_d.ds_s1 = link.dstrobe;
    s_d.ds_s2 = s_q.ds_s1;
    s_d.ds_s3 = s_q.ds_s2;
    s_d.rd_s1 = link.rdata;
    // data sampled on each strobe edge, rising and falling
    if (s_q.ds_s2 != s_q.ds_s3)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata = s_q.rd_s1;
    end
    unique case (s_q.st)
      CHHS_H_IDLE:
        if (wr_req_in && s_q.rdy_s2 && !(ide_sel_in && !wr_io_in))
        begin
          s_d.io = wr_io_in;
          s_d.wdata = wr_data_in;
          s_d.st = CHHS_H_STROBE;
        end
      CHHS_H_STROBE:
      begin
        s_d.we_n = s_q.io;
        s_d.iowr_n = !s_q.io;
        s_d.hold = chhs_pkg::CHHS_HOLD_CYC; // card must see the fall and its wait must come back through the sync
        s_d.st = CHHS_H_HOLD;
      end
      CHHS_H_HOLD:
        if (s_q.hold != 4'h0)
          s_d.hold = s_q.hold - 4'h1;
        else if (s_q.wt_s2)
        begin
          s_d.we_n = 1'b1;
          s_d.iowr_n = 1'b1;
          s_d.done = 1'b1;
          s_d.st = CHHS_H_IDLE;
        end
    endcase
  end
  // single state register
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      s_q <= '0;
      s_q.st <= CHHS_H_IDLE;
      s_q.we_n <= 1'b1;
      s_q.iowr_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end
  // pin drive
  assign link.link_clk = s_q.lclk;
  assign link.reset_n = rst_n_in;
  assign link.ide_mode_select_n = !ide_sel_in;
  assign link.io_mode = io_sel_in;
  assign link.we_n = ide_sel_in ? 1'b1 : s_q.we_n;
  assign link.iowr_n = s_q.iowr_n;
  assign link.udma_wr = 1'b0;
  assign link.udma_rd = rd_burst_in;
  assign link.host_pause = rd_pause_in;
  assign link.word_port = 1'b1;
  assign link.wdata = s_q.wdata;
  assign wr_done_out = s_q.done;
  assign rd_valid_out = s_q.rvalid;
  assign rd_data_out = s_q.rdata;
endmodule

//--- verification/chhs_props.sv
// checker of the handshake relations on the card host link
`timescale 1ns/1ps
module chhs_props
(
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic ide_mode_select_n,
  input wire logic io_mode,
  input wire logic we_n,
  input wire logic iowr_n,
  input wire logic udma_rd,
  input wire logic host_pause,
  input wire logic word_port,
  input wire logic ready,
  input wire logic wait_n,
  input wire logic wp_16_n,
  input wire logic dstrobe
);
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!reset_n);
  // a strobe starts a cycle, the card stretches it for three link cycles
  sequence strobe_fall_s; $fell(we_n) || $fell(iowr_n); endsequence
  sequence stretch_s; ##[0:4] !wait_n [*3]; endsequence
  sequence mode_still_s; $stable(ide_mode_select_n) && $stable(io_mode) && $stable(word_port); endsequence
  cycle_stretch_a: assert property (strobe_fall_s |-> stretch_s) else $error("wait stretch wrong");
  strobe_hold_a: assert property (!wait_n |-> (!we_n || !iowr_n)) else $error("strobe ended in wait");
  init_busy_a: assert property ($rose(reset_n) |-> !ready [*8] ##[1:5] ready) else $error("init busy wrong");
  wp_low_a: assert property ((ready && ide_mode_select_n && !io_mode) and mode_still_s |-> !wp_16_n)
    else $error("wp not low");
  port16_a: assert property ((ready && ide_mode_select_n && io_mode) and mode_still_s |-> wp_16_n == !word_port)
    else $error("port width wrong");
  word_xfer_a: assert property ((ready && !ide_mode_select_n && $stable(udma_rd)) and mode_still_s
    |-> wp_16_n == !(word_port && udma_rd)) else $error("word flag wrong");
  ide_we_a: assert property (!ide_mode_select_n |-> we_n) else $error("we low in ide");
  pause_still_a: assert property ((host_pause && udma_rd) [*4] |-> $stable(dstrobe)) else $error("edge in pause");
  idle_still_a: assert property ((!udma_rd) [*4] |-> $stable(dstrobe)) else $error("edge out of burst");
endmodule

//--- verification/card_host_handshake_signals_test.sv
// testbench joining card and host ends and checking transfers in all modes
`timescale 1ns/1ps
module card_host_handshake_signals_test;
  logic        clk_in, rst_n_in, core_busy_in, ide_sel_in, io_sel_in, wr_req_in, wr_io_in;
  logic        rd_burst_in, rd_pause_in, cfg_valid_out, wr_done_out, rd_valid_out, ok;
  logic [15:0] wr_data_in, rd_data_in, cfg_data_out, task_data_out, rd_data_out;
  int          n_errors, n_checks, cyc, n;
  chhs_if link ();
  chhs_card chhs_card_inst (.link(link), .clk_in(clk_in), .rst_n_in(rst_n_in), .core_busy_in(core_busy_in),
    .cfg_valid_out(cfg_valid_out), .cfg_data_out(cfg_data_out), .task_data_out(task_data_out), .rd_data_in(rd_data_in));
  chhs_host chhs_host_inst (.link(link), .clk_in(clk_in), .rst_n_in(rst_n_in), .ide_sel_in(ide_sel_in),
    .io_sel_in(io_sel_in), .wr_req_in(wr_req_in), .wr_io_in(wr_io_in), .wr_data_in(wr_data_in),
    .rd_burst_in(rd_burst_in), .rd_pause_in(rd_pause_in), .wr_done_out(wr_done_out),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out));
  chhs_props chhs_props_inst (.link_clk(link.link_clk), .reset_n(link.reset_n),
    .ide_mode_select_n(link.ide_mode_select_n), .io_mode(link.io_mode), .we_n(link.we_n), .iowr_n(link.iowr_n),
    .udma_rd(link.udma_rd), .host_pause(link.host_pause), .word_port(link.word_port), .ready(link.ready),
    .wait_n(link.wait_n), .wp_16_n(link.wp_16_n), .dstrobe(link.dstrobe));
  // main clock
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one host write, held until done or the limit runs out
  task automatic wr(input logic io, input logic [15:0] d, input int lim);
    @(posedge clk_in);
    wr_req_in  <= 1'b1;
    wr_io_in   <= io;
    wr_data_in <= d;
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++)
    begin
      @(posedge clk_in);
      ok = (wr_done_out === 1'b1);
    end
    wr_req_in <= 1'b0;
    repeat (20) @(posedge clk_in);
  endtask
  task automatic mode(input logic ide, input logic io);
    @(posedge clk_in);
    ide_sel_in <= ide;
    io_sel_in  <= io;
    repeat (30) @(posedge clk_in);
  endtask
  // count read words over a window, each must carry the card's data
  task automatic burst(input logic pause);
    rd_pause_in <= pause;
    n = 0;
    repeat (12) @(posedge clk_in);
    repeat (40)
    begin
      @(posedge clk_in);
      if (rd_valid_out === 1'b1)
      begin
        n++;
        chk(rd_data_out, rd_data_in);
      end
    end
  endtask
  // hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    {rst_n_in, core_busy_in, ide_sel_in, io_sel_in, wr_req_in, wr_io_in, rd_burst_in, rd_pause_in} = 8'h00;
    wr_data_in = 16'h0000;
    rd_data_in = 16'hA5C3;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (80) @(posedge clk_in);
    chk(16'(link.ready), 16'h0001);
    mode(1'b0, 1'b0);
    chk(16'(link.wp_16_n), 16'h0000);
    wr(1'b0, 16'h1234, 300);
    chk(cfg_data_out, 16'h1234);
    mode(1'b0, 1'b1);
    wr(1'b0, 16'h5A5A, 300);
    chk(cfg_data_out, 16'h5A5A);
    wr(1'b1, 16'hC3C3, 300);
    chk(task_data_out, 16'hC3C3);
    chk(cfg_data_out, 16'h5A5A);
    core_busy_in <= 1'b1;
    wr(1'b1, 16'h0F0F, 40);
    chk(16'(ok), 16'h0000);
    core_busy_in <= 1'b0;
    wr(1'b1, 16'h0F0F, 300);
    chk(task_data_out, 16'h0F0F);
    mode(1'b1, 1'b0);
    chk(16'(link.ide_mode_select_n), 16'h0000);
    wr(1'b1, 16'h7E81, 300);
    chk(task_data_out, 16'h7E81);
    chk(cfg_data_out, 16'h5A5A);
    rd_burst_in <= 1'b1;
    burst(1'b0);
    chk(16'(n > 0), 16'h0001);
    burst(1'b1);
    chk(16'(n), 16'h0000);
    burst(1'b0);
    chk(16'(n > 0), 16'h0001);
    rd_burst_in <= 1'b0;
    results();
  end
endmodule
